/* rtl/trf_core.sv */
// tape record formatter: memory-to-tape framing and tape-to-memory unpacking
// Overview of operation
// [R1] seven-track frames hold the six information bits of one character plus parity.
// [R2] nine-track standard packing puts four characters into three eight-bit frames.
// [R3] word marks and item marks never reach the tape.
// [R4] memory characters arrive without parity and every frame gets fresh parity.
// [R5] odd mode gives every frame an odd one count, even mode an even one.
// [R6] one longitudinal check frame follows the last data frame of each record.
// [R7] a write ends before the record-mark position, which is never recorded.
// [R8] on a read, a record-mark position takes one tape character, then transfer stops.
// [R9] after such a stop the tape keeps moving until the next gap is sensed.
// [R10] tape operations never alter punctuation in memory.
// [R11] records on tape are separated by blank gaps, not by mark characters.
// [R12] the processor places a record mark just after the last record character.
// [R13] the processor supplies the leftmost record address as the start address.
// [R14] completion is signalled only once the gap ending the record is reached.
`timescale 1ns/1ps
module trf_core (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       start_i,
	input  wire logic                       write_i,
	input  wire logic                       nine_track_i,
	input  wire logic                       odd_par_i,
	input  wire logic [trf_pkg::ADDR_W-1:0] start_addr_i,
	output logic                            busy_o,
	output logic                            done_o,
	output logic                            mem_req_o,
	output logic                            mem_we_o,
	output logic [trf_pkg::ADDR_W-1:0]      mem_addr_o,
	output logic [trf_pkg::CHAR_W-1:0]      mem_wdata_o,
	input  wire trf_pkg::trf_char_t         mem_rdata_i,
	input  wire logic                       mem_ack_i,
	output logic                            tape_run_o,
	output logic                            tape_wr_o,
	output trf_pkg::trf_frame_t             tape_frame_o,
	input  wire logic                       tape_rdy_i,
	output logic                            tape_gap_req_o,
	input  wire logic                       tape_gap_i,
	input  wire logic                       tape_rd_vld_i,
	input  wire logic [7:0]                 tape_rd_data_i,
	output logic                            tape_rd_rdy_o
);

	trf_pkg::trf_state_t s_reg;
	trf_pkg::trf_state_t s_next;

	// frame parity for the selected sense
	function automatic logic par_of(input logic [7:0] d, input logic odd);
		par_of = odd ? ~(^d) : (^d);
	endfunction

	// record mark: word mark and item mark together
	function automatic logic is_mark(input trf_pkg::trf_char_t c);
		is_mark = c.wm && c.im;
	endfunction

	// data byte of the next outgoing frame
	function automatic logic [7:0] data_of(input trf_pkg::trf_state_t x);
		if (x.st == trf_pkg::ST_W_LRC)
			data_of = x.lrc;
		else if (x.nine)
			data_of = x.sr[23:16];
		else
			data_of = {2'b00, x.sr[5:0]};
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		case (s_reg.st)
			trf_pkg::ST_IDLE: begin
				if (start_i) begin
					s_next.addr = start_addr_i; // R13
					s_next.nine = nine_track_i;
					s_next.odd = odd_par_i; // R5
					s_next.sr = trf_pkg::SR_RST;
					s_next.cnt = 3'h0;
					s_next.pend = 3'h0;
					s_next.fc = 2'h0;
					s_next.lrc = 8'h00;
					s_next.mark = 1'b0;
					s_next.hvalid = 1'b0;
					s_next.st = write_i ? trf_pkg::ST_W_FETCH
						: trf_pkg::ST_R_WAIT;
				end
			end
			trf_pkg::ST_W_FETCH: begin
				if (mem_ack_i) begin
					if (is_mark(mem_rdata_i)) begin
						// flush a partial nine-track group
						s_next.pend = s_reg.nine ? s_reg.cnt : 3'h0; // R7
						s_next.sr = s_reg.sr << (6 * (4 - s_reg.cnt));
						s_next.mark = 1'b1;
						s_next.st = (s_next.pend == 3'h0) ?
							trf_pkg::ST_W_LRC : trf_pkg::ST_W_EMIT; // R6
					end else begin
						// punctuation dropped, only info bits kept
						s_next.sr = {s_reg.sr[17:0], mem_rdata_i.info}; // R3
						s_next.addr = s_reg.addr + 1'b1;
						if (!s_reg.nine) begin
							s_next.pend = trf_pkg::SEVEN_FRM; // R1
							s_next.st = trf_pkg::ST_W_EMIT;
						end else if (s_reg.cnt == trf_pkg::NINE_FRMS) begin
							s_next.cnt = 3'h0;
							s_next.pend = trf_pkg::NINE_FRMS; // R2
							s_next.st = trf_pkg::ST_W_EMIT;
						end else begin
							s_next.cnt = s_reg.cnt + 3'h1;
						end
					end
				end
			end
			trf_pkg::ST_W_EMIT: begin
				if (tape_rdy_i) begin
					s_next.lrc = s_reg.lrc ^ s_reg.frm.data; // R6
					s_next.sr = s_reg.sr << 8;
					s_next.pend = s_reg.pend - 3'h1;
					if (s_reg.pend == 3'h1)
						s_next.st = s_reg.mark ? trf_pkg::ST_W_LRC
							: trf_pkg::ST_W_FETCH;
				end
			end
			trf_pkg::ST_W_LRC: begin
				if (tape_rdy_i)
					s_next.st = trf_pkg::ST_W_GAP; // R11
			end
			trf_pkg::ST_W_GAP: begin
				if (tape_gap_i) begin
					s_next.done = 1'b1; // R14
					s_next.st = trf_pkg::ST_IDLE;
				end
			end
			trf_pkg::ST_R_WAIT: begin
				if (tape_gap_i) begin
					// last held frame is the check frame: discarded
					s_next.done = 1'b1; // R14
					s_next.st = trf_pkg::ST_IDLE;
				end else if (tape_rd_vld_i) begin
					s_next.held = tape_rd_data_i;
					s_next.hvalid = 1'b1;
					if (s_reg.hvalid && !s_reg.nine) begin
						s_next.sr = {s_reg.held[5:0], 18'h0_0000};
						s_next.pend = trf_pkg::SEVEN_FRM;
						s_next.st = trf_pkg::ST_R_CHK;
					end else if (s_reg.hvalid) begin
						s_next.sr = {s_reg.sr[15:0], s_reg.held};
						s_next.fc = s_reg.fc + 2'h1;
						if (s_reg.fc == trf_pkg::FRM_LAST) begin
							s_next.fc = 2'h0;
							s_next.pend = trf_pkg::NINE_CHRS; // R2
							s_next.st = trf_pkg::ST_R_CHK;
						end
					end
				end
			end
			trf_pkg::ST_R_CHK: begin
				if (mem_ack_i) begin
					s_next.mark = is_mark(mem_rdata_i);
					s_next.st = trf_pkg::ST_R_STORE;
				end
			end
			trf_pkg::ST_R_STORE: begin
				if (mem_ack_i) begin
					s_next.addr = s_reg.addr + 1'b1;
					s_next.sr = s_reg.sr << 6;
					s_next.pend = s_reg.pend - 3'h1;
					if (s_reg.mark)
						s_next.st = trf_pkg::ST_R_SKIP; // R8
					else if (s_reg.pend == 3'h1)
						s_next.st = trf_pkg::ST_R_WAIT;
					else
						s_next.st = trf_pkg::ST_R_CHK;
				end
			end
			trf_pkg::ST_R_SKIP: begin
				if (tape_gap_i) begin
					s_next.done = 1'b1; // R9
					s_next.st = trf_pkg::ST_IDLE;
				end
			end
			default: s_next.st = trf_pkg::ST_IDLE;
		endcase
		s_next.frm.data = data_of(s_next);
		s_next.frm.par = par_of(data_of(s_next), s_next.odd); // R4
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.st <= trf_pkg::ST_IDLE;
			s_reg.addr <= trf_pkg::ADDR_RST;
			s_reg.sr <= trf_pkg::SR_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy_o = (s_reg.st != trf_pkg::ST_IDLE);
	assign done_o = s_reg.done;
	assign tape_run_o = busy_o; // R9
	assign mem_req_o = (s_reg.st == trf_pkg::ST_W_FETCH) ||
		(s_reg.st == trf_pkg::ST_R_CHK) || (s_reg.st == trf_pkg::ST_R_STORE);
	// only info bits are written; memory keeps its punctuation
	assign mem_we_o = (s_reg.st == trf_pkg::ST_R_STORE); // R10
	assign mem_addr_o = s_reg.addr;
	assign mem_wdata_o = s_reg.sr[23:18];
	assign tape_wr_o = (s_reg.st == trf_pkg::ST_W_EMIT) ||
		(s_reg.st == trf_pkg::ST_W_LRC);
	assign tape_frame_o = s_reg.frm;
	assign tape_gap_req_o = (s_reg.st == trf_pkg::ST_W_GAP);
	assign tape_rd_rdy_o = (s_reg.st == trf_pkg::ST_R_WAIT) ||
		(s_reg.st == trf_pkg::ST_R_SKIP);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	frame_parity_a: assert property ( // R5
		tape_wr_o |-> ((^tape_frame_o) == s_reg.odd))
		else $error("frame parity sense wrong");
	seven_width_a: assert property ( // R1
		tape_wr_o && !s_reg.nine |-> tape_frame_o.data[7:6] == 2'b00)
		else $error("seven-track frame uses upper channels");
	nine_pack_a: assert property ( // R2
		s_reg.st == trf_pkg::ST_W_FETCH && mem_ack_i && s_reg.nine &&
		!(mem_rdata_i.wm && mem_rdata_i.im) && s_reg.cnt == 3'h3
		|=> s_reg.st == trf_pkg::ST_W_EMIT && s_reg.pend == 3'h3
		##1 tape_wr_o)
		else $error("fourth character does not yield three frames");
	mark_skip_a: assert property ( // R7
		s_reg.st == trf_pkg::ST_W_FETCH && mem_ack_i && s_reg.cnt == 3'h0 &&
		mem_rdata_i.wm && mem_rdata_i.im
		|=> s_reg.st == trf_pkg::ST_W_LRC && s_reg.addr == $past(s_reg.addr))
		else $error("record mark position handled as data");
	check_frame_a: assert property ( // R6
		s_reg.st == trf_pkg::ST_W_LRC && tape_rdy_i
		|-> tape_frame_o.data == s_reg.lrc ##1 tape_gap_req_o)
		else $error("check frame missing before gap");
	read_stop_a: assert property ( // R8
		s_reg.st == trf_pkg::ST_R_STORE && mem_ack_i && s_reg.mark
		|=> !mem_req_o [*2])
		else $error("transfer continues past record mark");
	skip_run_a: assert property ( // R9
		s_reg.st == trf_pkg::ST_R_SKIP && !tape_gap_i
		|=> tape_run_o && !done_o)
		else $error("tape stopped before gap");
	gap_after_lrc_a: assert property ( // R11
		$rose(tape_gap_req_o) |-> $past(tape_wr_o))
		else $error("gap not preceded by check frame");
	done_gap_a: assert property ( // R14
		done_o |-> $past(tape_gap_i) && !busy_o)
		else $error("done without gap");

endmodule

/* rtl/trf_pkg.sv */
// shared types and constants of the tape record formatter
package trf_pkg;

	localparam int unsigned ADDR_W    = 16;
	localparam int unsigned CHAR_W    = 6;
	localparam int unsigned SHIFT_W   = 24;
	localparam logic [2:0]  NINE_CHRS = 3'h4;
	localparam logic [2:0]  NINE_FRMS = 3'h3;
	localparam logic [2:0]  SEVEN_FRM = 3'h1;
	localparam logic [1:0]  FRM_LAST  = 2'h2;

	// memory character as seen by the channel; stored parity is not carried
	typedef struct packed {
		logic              wm;
		logic              im;
		logic [CHAR_W-1:0] info;
	} trf_char_t;

	typedef struct packed {
		logic [7:0] data;
		logic       par;
	} trf_frame_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_W_FETCH, ST_W_EMIT, ST_W_LRC, ST_W_GAP,
		ST_R_WAIT, ST_R_CHK, ST_R_STORE, ST_R_SKIP
	} trf_st_t;

	typedef struct packed {
		trf_st_t            st;
		logic [ADDR_W-1:0]  addr;
		logic [SHIFT_W-1:0] sr;
		logic [2:0]         cnt;
		logic [2:0]         pend;
		logic [1:0]         fc;
		logic [7:0]         lrc;
		logic               nine;
		logic               odd;
		logic               mark;
		logic               hvalid;
		logic [7:0]         held;
		trf_frame_t         frm;
		logic               done;
	} trf_state_t;

	localparam logic [SHIFT_W-1:0] SR_RST   = 24'h00_0000;
	localparam logic [ADDR_W-1:0]  ADDR_RST = 16'h0000;

endpackage

/* tb/trf_tape_model.sv */
// behavioural tape transport at the far side of the formatter
`timescale 1ns/1ps
module trf_tape_model (
	input  wire logic                clk_i,
	input  wire logic                rd_go_i,
	input  wire logic                tape_run_i,
	input  wire logic                tape_wr_i,
	input  wire trf_pkg::trf_frame_t tape_frame_i,
	output logic                     tape_rdy_o,
	input  wire logic                tape_gap_req_i,
	output logic                     tape_gap_o,
	output logic                     tape_rd_vld_o,
	output logic [7:0]               tape_rd_data_o,
	input  wire logic                tape_rd_rdy_i
);
	trf_pkg::trf_frame_t wq[$];
	logic [7:0]          rq[$];
	initial begin
		tape_rdy_o = 1'b0;
		tape_gap_o = 1'b0;
		tape_rd_vld_o = 1'b0;
		tape_rd_data_o = 8'h00;
	end
	always @(posedge clk_i) begin
		if (tape_wr_i && tape_rdy_o)
			wq.push_back(tape_frame_i);
		if (tape_rd_vld_o && tape_rd_rdy_i)
			void'(rq.pop_front());
	end
	// slow taker: ready only every other cycle
	always @(negedge clk_i) begin
		tape_rdy_o <= tape_wr_i && !tape_rdy_o;
		tape_rd_vld_o <= rq.size() != 0;
		tape_rd_data_o <= (rq.size() != 0) ? rq[0] : ~tape_rd_data_o;
		tape_gap_o <= !tape_gap_o && (tape_gap_req_i ||
			(rd_go_i && tape_run_i && rq.size() == 0));
	end
endmodule

/* tb/trf_core_test.sv */
// self-checking bench of the tape record formatter
`timescale 1ns/1ps
module trf_core_test;
	logic                clk = 0, rst = 1, start = 0, wr = 0, nine = 0;
	logic                odd = 0, ack = 0, rd_go = 0;
	logic                busy, done, req, we, run, twr, rdy, greq, gap;
	logic                vld, rrdy;
	logic [15:0]         maddr;
	logic [5:0]          wdata;
	logic [7:0]          rdat;
	trf_pkg::trf_char_t  rdata = '0;
	trf_pkg::trf_char_t  mem [0:7];
	trf_pkg::trf_frame_t frame;
	int                  fails = 0, checked = 0, cyc = 0;
	always #2.5 clk = ~clk;
	trf_core u_dut (.clk_i(clk), .rst_i(rst), .start_i(start),
		.write_i(wr), .nine_track_i(nine), .odd_par_i(odd),
		.start_addr_i(16'h0000), .busy_o(busy), .done_o(done),
		.mem_req_o(req), .mem_we_o(we), .mem_addr_o(maddr),
		.mem_wdata_o(wdata), .mem_rdata_i(rdata), .mem_ack_i(ack),
		.tape_run_o(run), .tape_wr_o(twr), .tape_frame_o(frame),
		.tape_rdy_i(rdy), .tape_gap_req_o(greq), .tape_gap_i(gap),
		.tape_rd_vld_i(vld), .tape_rd_data_i(rdat),
		.tape_rd_rdy_o(rrdy));
	trf_tape_model u_tape (.clk_i(clk), .rd_go_i(rd_go),
		.tape_run_i(run), .tape_wr_i(twr), .tape_frame_i(frame),
		.tape_rdy_o(rdy), .tape_gap_req_i(greq), .tape_gap_o(gap),
		.tape_rd_vld_o(vld), .tape_rd_data_o(rdat),
		.tape_rd_rdy_i(rrdy));
	// memory answers with no wait state
	always @(negedge clk) begin
		ack <= req;
		rdata <= mem[maddr[2:0]];
	end
	always @(posedge clk)
		if (req && ack && we)
			mem[maddr[2:0]].info <= wdata;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	function automatic trf_pkg::trf_frame_t fr(logic [7:0] d, logic o);
		return '{d, o ? ~^d : ^d};
	endfunction
	task automatic cf(input trf_pkg::trf_frame_t e, input int k);
		chk("frame", {7'h00, e}, {7'h00, u_tape.wq[k]});
	endtask
	task automatic go(input logic w, n, o);
		int i;
		u_tape.wq.delete();
		@(negedge clk);
		start = 1;
		wr = w;
		nine = n;
		odd = o;
		@(negedge clk);
		start = 0;
		for (i = 0; i < 400 && done !== 1'b1; i++)
			@(negedge clk);
		chk("done", 16'h0001, {15'h0000, done});
		chk("idle", 16'h0000, {14'h0000, busy, run});
	endtask
	// seven-track write, odd parity, punctuated chars, record mark
	task automatic t_write7;
		mem[0] = '{1'b1, 1'b0, 6'h2D};
		mem[1] = '{1'b0, 1'b1, 6'h13};
		mem[2] = '{1'b1, 1'b1, 6'h3F};
		go(1, 0, 1);
		chk("nframes", 16'h0003, 16'(u_tape.wq.size()));
		cf(fr(8'h2D, 1), 0);
		cf(fr(8'h13, 1), 1);
		cf(fr(8'h3E, 1), 2);
	endtask
	// nine-track write, even parity, one full group
	task automatic t_write9;
		mem[0] = '{1'b0, 1'b0, 6'h21};
		mem[1] = '{1'b1, 1'b0, 6'h0C};
		mem[2] = '{1'b0, 1'b0, 6'h35};
		mem[3] = '{1'b0, 1'b1, 6'h1A};
		mem[4] = '{1'b1, 1'b1, 6'h00};
		go(1, 1, 0);
		chk("nframes", 16'h0004, 16'(u_tape.wq.size()));
		cf(fr({6'h21, 2'h0}, 0), 0);
		cf(fr({4'hC, 4'hD}, 0), 1);
		cf(fr({2'h1, 6'h1A}, 0), 2);
		cf(fr(8'h84 ^ 8'hCD ^ 8'h5A, 0), 3);
	endtask
	// seven-track read stopping at a record mark
	task automatic t_read7;
		mem[0] = '{1'b1, 1'b0, 6'h00};
		mem[1] = '{1'b1, 1'b1, 6'h00};
		mem[2] = '{1'b0, 1'b1, 6'h15};
		u_tape.rq = '{8'h2A, 8'h11, 8'h3C, 8'h05, 8'h12};
		rd_go = 1;
		go(0, 0, 1);
		rd_go = 0;
		chk("pos0", 16'h00AA, 16'(mem[0]));
		chk("pos1", 16'h00D1, 16'(mem[1]));
		chk("pos2", 16'h0055, 16'(mem[2]));
		chk("left", 16'h0000, 16'(u_tape.rq.size()));
	endtask
	// nine-track write, odd parity, partial group of two characters
	task automatic t_write9p;
		mem[0] = '{1'b0, 1'b1, 6'h2B};
		mem[1] = '{1'b1, 1'b0, 6'h07};
		mem[2] = '{1'b1, 1'b1, 6'h15};
		go(1, 1, 1);
		chk("nframes", 16'h0003, 16'(u_tape.wq.size()));
		cf(fr(8'hAC, 1), 0);
		cf(fr(8'h70, 1), 1);
		cf(fr(8'hDC, 1), 2);
	endtask
	// nine-track read ending at the gap, check frame dropped
	task automatic t_read9;
		mem[0] = '{1'b1, 1'b0, 6'h00};
		mem[1] = '{1'b0, 1'b0, 6'h00};
		mem[2] = '{1'b0, 1'b1, 6'h00};
		mem[3] = '{1'b0, 1'b0, 6'h00};
		mem[4] = '{1'b1, 1'b1, 6'h3F};
		u_tape.rq = '{8'h4B, 8'h42, 8'hFD, 8'hF4};
		rd_go = 1;
		go(0, 1, 0);
		rd_go = 0;
		chk("pos0", 16'h0092, 16'(mem[0]));
		chk("pos1", 16'h0034, 16'(mem[1]));
		chk("pos2", 16'h004B, 16'(mem[2]));
		chk("pos3", 16'h003D, 16'(mem[3]));
		chk("pos4", 16'h00FF, 16'(mem[4]));
		chk("left", 16'h0000, 16'(u_tape.rq.size()));
	endtask
	initial begin
		foreach (mem[i])
			mem[i] = '0;
		repeat (16) @(negedge clk);
		rst = 0;
		t_write7();
		t_write9();
		t_write9p();
		t_read7();
		t_read9();
		wrap_up();
	end
endmodule
